//--- shared/phy_regs_params.svh
/*
  constants of the port's basic control, status and identifier registers.
  assumes inclusion by bare name from the package; definitions only.
*/
`ifndef PHY_REGS_PARAMS_SVH
`define PHY_REGS_PARAMS_SVH

// ==========================================================
// register addresses and page
`define CTRL_ADDR 5'h00
`define STAT_ADDR 5'h01
`define ID_HI_ADDR 5'h02
`define ID_LO_ADDR 5'h03
`define PAGE_ADDR 5'h1f
`define MAIN_PAGE 16'h0000
`define PAGE_RESET 16'h0000

// ==========================================================
// control register fields
`define CTRL_RESET 16'h1040
`define CTRL_WR_MASK 16'h7fc0
`define CTRL_SOFT_RST 15
`define CTRL_LOOPBACK 14
`define CTRL_SPEED_LSB 13
`define CTRL_AN_EN 12
`define CTRL_PDOWN 11
`define CTRL_ISOLATE 10
`define CTRL_AN_RESTART 9
`define CTRL_DUPLEX 8
`define CTRL_COLL_TEST 7
`define CTRL_SPEED_MSB 6

// ==========================================================
// status register fields
`define STAT_FIXED 16'h79c9
`define LATCH_N 3
`define LATCH_LOW_MASK 3'h2
`define LATCH_RESET 3'h0

// ==========================================================
// management frame
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define HDR_LAST 5'h0b
`define TA_LAST 5'h01
`define DATA_LAST 5'h0f
`define MAC_DATA_W 8

`endif

//--- shared/phy_regs_pkg.sv
/*
  types of the port register block: frame states and state records.
  assumes the constants header is on the include path.
*/
package phy_regs_pkg;
  `include "phy_regs_params.svh"

  // ==========================================================
  // types
  typedef enum logic [2:0] {S_IDLE, S_START, S_HEAD, S_TA, S_WDATA, S_RDATA} mgmt_state_t;

  typedef struct packed {
    logic mdc_q;
    mgmt_state_t state;
    logic [4:0] cnt;
    logic [15:0] shift;
    logic op_read;
    logic mine;
    logic [4:0] reg_addr;
    logic mdio_out;
    logic mdio_oe;
    logic [15:0] ctrl;
    logic [15:0] page;
    logic soft_rst;
    logic an_restart;
    logic loopback;
    logic [1:0] speed;
    logic full_duplex;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic coll_test;
    logic mac_rx_valid;
    logic [`MAC_DATA_W-1:0] mac_rxd;
    logic mac_col;
    logic line_tx_en;
    logic [`MAC_DATA_W-1:0] line_txd;
  } port_state_t;

  typedef struct packed {
    logic [`LATCH_N-1:0] held;
  } latch_state_t;
endpackage : phy_regs_pkg

//--- rtl/status_latch_bank.sv
/*
  latched status bits, each latching high or low and released by a read.
  assumes live inputs synchronous to clk and a one-cycle read pulse.
*/
`include "phy_regs_params.svh"
module status_latch_bank
  import phy_regs_pkg::*;
#(
  parameter logic [`LATCH_N-1:0] LATCH_LOW = `LATCH_LOW_MASK
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_clr,
  input wire logic rd_clr,
  input wire logic [`LATCH_N-1:0] live,
  output logic [`LATCH_N-1:0] held
);
  latch_state_t st;
  latch_state_t n;

  // ==========================================================
  // next state
  always_comb begin
    n = st;
    for (int i = 0; i < `LATCH_N; i++) begin
      // a live event in the read cycle wins over the release
      if (LATCH_LOW[i]) begin
        n.held[i] = live[i] & (st.held[i] | rd_clr);
      end else begin
        n.held[i] = live[i] | (st.held[i] & ~rd_clr);
      end
    end
    if (soft_clr) begin
      // an event in the soft reset cycle still latches
      n.held = `LATCH_RESET | (live & ~LATCH_LOW);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{held: `LATCH_RESET};
    end else begin
      st <= n;
    end
  end

  assign held = st.held;

  // ==========================================================
  // checks
  for (genvar g = 0; g < `LATCH_N; g++) begin : g_chk
    if (LATCH_LOW[g]) begin : g_low
      a_low_catch: assert property (@(posedge clk) disable iff (rst)
        !live[g] |=> !held[g] ##1 (!held[g] || $past(rd_clr)))
        else $error("link latch did not hold low");
    end else begin : g_high
      a_high_hold: assert property (@(posedge clk) disable iff (rst)
        live[g] ##1 (!rd_clr && !soft_clr) [*2] |=> held[g])
        else $error("latched event was lost before a read");
    end
  end
endmodule : status_latch_bank

//--- rtl/phy_basic_control_status_regs.sv
/*
  basic control, status and identifier registers of one transceiver port,
  with the management serial port frame engine that reaches them.
  assumes MDC and MDIO_IN are already synchronous to CLOCK and much slower,
  and that the line datapath and negotiation logic sit outside.
*/
`include "phy_regs_params.svh"
module phy_basic_control_status_regs
  import phy_regs_pkg::*;
#(
  // identifier values are arbitrary
  parameter int unsigned OUI_HIGH = 'h5a3c,
  parameter int unsigned OUI_LOW = 'h15,
  parameter int unsigned MODEL_NUM = 'h0b,
  parameter int unsigned REV_NUM = 'h3
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [4:0] PHY_ADDR,
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE,
  input wire logic LINK_UP,
  input wire logic AN_DONE,
  input wire logic FAR_FAULT,
  input wire logic JABBER_SEEN,
  input wire logic MAC_TX_EN_IN,
  input wire logic [`MAC_DATA_W-1:0] MAC_TXD_IN,
  input wire logic LINE_RX_VALID,
  input wire logic [`MAC_DATA_W-1:0] LINE_RXD,
  input wire logic LINE_COL,
  output logic MAC_RX_VALID,
  output logic [`MAC_DATA_W-1:0] MAC_RXD,
  output logic MAC_COL,
  output logic LINE_TX_EN,
  output logic [`MAC_DATA_W-1:0] LINE_TXD,
  output logic LOOPBACK,
  output logic [1:0] SPEED_SEL,
  output logic FULL_DUPLEX,
  output logic AN_ENABLE,
  output logic AN_RESTART,
  output logic POWER_DOWN,
  output logic ISOLATE,
  output logic COLL_TEST,
  output logic SOFT_RESET
);
  // ==========================================================
  // parameter checks
  if (OUI_HIGH > 'hffff || OUI_LOW > 'h3f || MODEL_NUM > 'h3f || REV_NUM > 'hf) begin : g_bad
    $error("identifier parameter does not fit its field");
  end

  // ==========================================================
  // decode
  // page zero gate
  function automatic logic main_hit(input logic [15:0] page, input logic [4:0] addr,
                                    input logic [4:0] want);
    return (page == `MAIN_PAGE) && (addr == want);
  endfunction : main_hit

  port_state_t st;
  port_state_t n;
  logic rise;
  logic [15:0] sh_n;
  logic hdr_done;
  logic hdr_mine;
  logic hdr_read;
  logic wr_now;
  logic ctrl_wr;
  logic soft_now;
  logic rd_stat_now;
  logic [15:0] status_word;
  logic [15:0] rd_word;
  logic [`LATCH_N-1:0] latch_live;
  logic [`LATCH_N-1:0] latch_held;
  logic tx_en_eff;

  assign rise = MDC && !st.mdc_q;
  assign sh_n = {st.shift[14:0], MDIO_IN};
  assign hdr_done = rise && (st.state == S_HEAD) && (st.cnt == `HDR_LAST);
  assign hdr_mine = (sh_n[9:5] == PHY_ADDR);
  assign hdr_read = (sh_n[11:10] == `OP_READ);
  assign wr_now = rise && (st.state == S_WDATA) && (st.cnt == `DATA_LAST) && st.mine
                  && !st.op_read;
  assign ctrl_wr = wr_now && main_hit(st.page, st.reg_addr, `CTRL_ADDR);
  assign soft_now = ctrl_wr && sh_n[`CTRL_SOFT_RST];
  // reading the status word is what releases the latches
  assign rd_stat_now = hdr_done && hdr_mine && hdr_read
                       && main_hit(st.page, sh_n[4:0], `STAT_ADDR);

  // ==========================================================
  // latched status
  // bit 0 jabber, bit 1 link, bit 2 remote fault
  assign latch_live = {FAR_FAULT, LINK_UP, JABBER_SEEN};

  status_latch_bank u_latch (
    .clk(CLOCK),
    .rst(RESET),
    .soft_clr(soft_now),
    .rd_clr(rd_stat_now),
    .live(latch_live),
    .held(latch_held)
  );

  assign status_word = `STAT_FIXED | {10'h000, AN_DONE, latch_held[2], 1'h0,
                                      latch_held[1], latch_held[0], 1'h0};

  // ==========================================================
  // read data
  always_comb begin
    rd_word = 16'h0000;
    if (sh_n[4:0] == `PAGE_ADDR) begin
      rd_word = st.page;
    end else if (main_hit(st.page, sh_n[4:0], `CTRL_ADDR)) begin
      rd_word = st.ctrl;
    end else if (main_hit(st.page, sh_n[4:0], `STAT_ADDR)) begin
      rd_word = status_word;
    end else if (main_hit(st.page, sh_n[4:0], `ID_HI_ADDR)) begin
      rd_word = 16'(OUI_HIGH);
    end else if (main_hit(st.page, sh_n[4:0], `ID_LO_ADDR)) begin
      rd_word = {6'(OUI_LOW), 6'(MODEL_NUM), 4'(REV_NUM)};
    end
  end

  // ==========================================================
  // next state
  // isolate means MAC inputs count for nothing at all
  assign tx_en_eff = MAC_TX_EN_IN && !st.isolate;

  always_comb begin
    n = st;
    n.mdc_q = MDC;
    n.soft_rst = 1'h0;
    n.an_restart = 1'h0;
    if (rise) begin
      case (st.state)
        S_IDLE: begin
          // preamble is optional; a zero opens the frame
          if (!MDIO_IN) begin
            n.state = S_START;
          end
        end
        S_START: begin
          n.state = MDIO_IN ? S_HEAD : S_IDLE;
          n.cnt = 5'h00;
        end
        S_HEAD: begin
          n.shift = sh_n;
          n.cnt = st.cnt + 5'h01;
          if (hdr_done) begin
            n.op_read = hdr_read;
            n.mine = hdr_mine && (hdr_read || sh_n[11:10] == `OP_WRITE);
            n.reg_addr = sh_n[4:0];
            n.cnt = 5'h00;
            n.state = S_TA;
            if (hdr_read) begin
              n.shift = rd_word;
            end
          end
        end
        S_TA: begin
          n.cnt = st.cnt + 5'h01;
          if (st.op_read && st.mine) begin
            n.mdio_oe = 1'h1;
            n.mdio_out = 1'h0;
          end
          if (st.cnt == `TA_LAST) begin
            n.cnt = 5'h00;
            n.state = st.op_read ? S_RDATA : S_WDATA;
            if (st.op_read && st.mine) begin
              n.mdio_out = st.shift[15];
              n.shift = {st.shift[14:0], 1'h0};
            end
          end
        end
        S_WDATA: begin
          n.shift = sh_n;
          n.cnt = st.cnt + 5'h01;
          if (st.cnt == `DATA_LAST) begin
            n.state = S_IDLE;
          end
        end
        S_RDATA: begin
          n.cnt = st.cnt + 5'h01;
          n.mdio_out = st.shift[15];
          n.shift = {st.shift[14:0], 1'h0};
          if (st.cnt == `DATA_LAST) begin
            n.mdio_oe = 1'h0;
            n.mdio_out = 1'h0;
            n.state = S_IDLE;
          end
        end
        default: begin
          n.state = S_IDLE;
        end
      endcase
    end

    // register writes; the page select is reachable on any page
    if (wr_now && st.reg_addr == `PAGE_ADDR) begin
      n.page = sh_n;
    end
    if (soft_now) begin
      // defaults back, latches cleared, frame engine untouched
      n.ctrl = `CTRL_RESET;
      n.page = `PAGE_RESET;
      n.soft_rst = 1'h1;
    end else if (ctrl_wr) begin
      n.ctrl = sh_n & `CTRL_WR_MASK & ~(16'h0001 << `CTRL_AN_RESTART);
      n.an_restart = sh_n[`CTRL_AN_RESTART];
    end

    // control outputs toward the port
    n.loopback = st.ctrl[`CTRL_LOOPBACK];
    // speed code, also used in loopback
    n.speed = {st.ctrl[`CTRL_SPEED_MSB], st.ctrl[`CTRL_SPEED_LSB]};
    n.full_duplex = st.ctrl[`CTRL_DUPLEX];
    n.an_enable = st.ctrl[`CTRL_AN_EN];
    n.power_down = st.ctrl[`CTRL_PDOWN];
    n.isolate = st.ctrl[`CTRL_ISOLATE];
    n.coll_test = st.ctrl[`CTRL_COLL_TEST];

    // MAC side datapath
    // loopback turns transmit back to receive
    if (st.loopback) begin
      n.mac_rx_valid = tx_en_eff;
      n.mac_rxd = MAC_TXD_IN;
    end else begin
      n.mac_rx_valid = LINE_RX_VALID;
      n.mac_rxd = LINE_RXD;
    end
    n.mac_col = st.coll_test ? tx_en_eff : LINE_COL;
    if (st.isolate) begin
      n.mac_rx_valid = 1'h0;
      n.mac_rxd = '0;
      n.mac_col = 1'h0;
    end
    // nothing goes to the line while down
    n.line_tx_en = tx_en_eff && !st.loopback && !st.power_down;
    n.line_txd = n.line_tx_en ? MAC_TXD_IN : '0;
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st <= '0;
      st.state <= S_IDLE;
      st.ctrl <= `CTRL_RESET;
      st.page <= `PAGE_RESET;
      st.speed <= 2'h2;
      st.an_enable <= 1'h1;
    end else begin
      st <= n;
    end
  end

  assign MDIO_OUT = st.mdio_out;
  assign MDIO_OE = st.mdio_oe;
  assign MAC_RX_VALID = st.mac_rx_valid;
  assign MAC_RXD = st.mac_rxd;
  assign MAC_COL = st.mac_col;
  assign LINE_TX_EN = st.line_tx_en;
  assign LINE_TXD = st.line_txd;
  assign LOOPBACK = st.loopback;
  assign SPEED_SEL = st.speed;
  assign FULL_DUPLEX = st.full_duplex;
  assign AN_ENABLE = st.an_enable;
  assign AN_RESTART = st.an_restart;
  assign POWER_DOWN = st.power_down;
  assign ISOLATE = st.isolate;
  assign COLL_TEST = st.coll_test;
  assign SOFT_RESET = st.soft_rst;

  // ==========================================================
  // checks
  // defaults after soft reset
  a_soft_reset_default: assert property (@(posedge CLOCK) disable iff (RESET)
    soft_now |=> SOFT_RESET && st.ctrl == `CTRL_RESET ##1 !SOFT_RESET)
    else $error("soft reset did not restore the control word");

  a_restart_pulse: assert property (@(posedge CLOCK) disable iff (RESET)
    (ctrl_wr && !soft_now && sh_n[`CTRL_AN_RESTART]) |=>
      AN_RESTART && !st.ctrl[`CTRL_AN_RESTART] ##1 !AN_RESTART)
    else $error("restart negotiation not a single pulse");

  a_speed_code: assert property (@(posedge CLOCK) disable iff (RESET)
    ##1 SPEED_SEL == {$past(st.ctrl[`CTRL_SPEED_MSB]), $past(st.ctrl[`CTRL_SPEED_LSB])})
    else $error("speed code mismatch");

  a_duplex_follow: assert property (@(posedge CLOCK) disable iff (RESET)
    $changed(st.ctrl[`CTRL_DUPLEX]) |=> FULL_DUPLEX == $past(st.ctrl[`CTRL_DUPLEX]))
    else $error("duplex output did not follow");

  a_loopback_path: assert property (@(posedge CLOCK) disable iff (RESET)
    (LOOPBACK && !ISOLATE) |=> MAC_RX_VALID == $past(MAC_TX_EN_IN) && !LINE_TX_EN)
    else $error("loopback path broken");

  a_isolate_quiet: assert property (@(posedge CLOCK) disable iff (RESET)
    ISOLATE |=> !MAC_RX_VALID && !MAC_COL && !LINE_TX_EN)
    else $error("MAC side active while isolated");

  a_coll_echo: assert property (@(posedge CLOCK) disable iff (RESET)
    (COLL_TEST && !ISOLATE) |=> MAC_COL == $past(MAC_TX_EN_IN))
    else $error("collision test did not echo transmit enable");

  a_page_gate: assert property (@(posedge CLOCK) disable iff (RESET)
    (wr_now && st.reg_addr == `CTRL_ADDR && st.page != `MAIN_PAGE) |=> $stable(st.ctrl))
    else $error("control written off the main page");

  a_power_quiet: assert property (@(posedge CLOCK) disable iff (RESET)
    POWER_DOWN |=> !LINE_TX_EN)
    else $error("line transmit while powered down");
endmodule : phy_basic_control_status_regs

//--- dv/mgmt_station.sv
/*
  station manager model: clocks frames on the management serial port.
  assumes the bench resolves the shared data wire with a pull-up.
*/
`include "phy_regs_params.svh"
module mgmt_station
  import phy_regs_pkg::*;
#(
  parameter int HALF = 3
) (
  input wire logic clk,
  input wire logic wire_lvl,
  output logic mdc,
  output logic drv_out,
  output logic drv_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mdc = 1'b0;
    drv_out = 1'b0;
    drv_oe = 1'b0;
  end

  // ==========================================
  // one frame; clock stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta_low);
    logic [33:0] f;
    f = {4'b1101, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    ta_low = 1'b0;
    for (int i = 0; i < 34; i++) begin
      @(negedge clk);
      mdc <= 1'b0;
      // let go before the port answers, pull-up covers the gap
      drv_oe <= !(op == `OP_READ && i >= 16);
      drv_out <= f[33-i];
      repeat (HALF - 1) @(negedge clk);
      if (i == 17) ta_low = !wire_lvl;
      if (i >= 18) rd = {rd[14:0], wire_lvl};
      mdc <= 1'b1;
      repeat (HALF) @(negedge clk);
    end
    @(negedge clk);
    mdc <= 1'b0;
    drv_oe <= 1'b0;
  endtask : frame

  task automatic to_main(input logic [4:0] phy);
    logic [15:0] d;
    logic t;
    frame(`OP_WRITE, phy, `PAGE_ADDR, `MAIN_PAGE, d, t);
  endtask : to_main

  task automatic force_gig(input logic [4:0] phy, input logic [15:0] ctl);
    logic [15:0] d;
    logic t;
    frame(`OP_WRITE, phy, 5'h09, 16'h0800, d, t);
    frame(`OP_WRITE, phy, `CTRL_ADDR, ctl | 16'h0800, d, t);
    frame(`OP_WRITE, phy, `CTRL_ADDR, ctl, d, t);
  endtask : force_gig
endmodule : mgmt_station

//--- dv/phy_basic_control_status_regs_test.sv
/*
  self-checking bench of the port register block with a station manager model.
  assumes the package and the manager model are compiled first.
*/
`include "phy_regs_params.svh"
module phy_basic_control_status_regs_test
  import phy_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] ME = 5'h05;
  // identifier values are arbitrary
  localparam int unsigned OHI = 'h2b71;
  localparam int unsigned OLO = 'h2e;
  localparam int unsigned MDL = 'h19;
  localparam int unsigned RV = 'h6;
  logic clock = 1'b0, reset = 1'b1, mdc, drv_out, drv_oe, mdio, mdio_out, mdio_oe;
  logic link_up, an_done, far_fault, jabber, tx_en, rx_valid, col;
  logic [7:0] txd, rxd, mac_rxd, line_txd, outs;
  logic mac_rx_valid, mac_col, line_tx_en, lb, fd, ane, anr, pd, iso, ct, srst;
  logic [1:0] spd;
  logic [31:0] seed = 32'hee3b;
  int n_fail = 0, samples_checked = 0, cycles = 0, n_restart = 0, n_soft = 0;

  assign mdio = mdio_oe ? mdio_out : (drv_oe ? drv_out : 1'b1);
  assign outs = {lb, spd, fd, ane, pd, iso, ct};
  always #10 clock = ~clock;

  phy_basic_control_status_regs #(.OUI_HIGH(OHI), .OUI_LOW(OLO), .MODEL_NUM(MDL),
    .REV_NUM(RV)) phy_basic_control_status_regs_inst (.CLOCK(clock), .RESET(reset),
    .PHY_ADDR(ME), .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe),
    .LINK_UP(link_up), .AN_DONE(an_done), .FAR_FAULT(far_fault), .JABBER_SEEN(jabber),
    .MAC_TX_EN_IN(tx_en), .MAC_TXD_IN(txd), .LINE_RX_VALID(rx_valid), .LINE_RXD(rxd),
    .LINE_COL(col), .MAC_RX_VALID(mac_rx_valid), .MAC_RXD(mac_rxd), .MAC_COL(mac_col),
    .LINE_TX_EN(line_tx_en), .LINE_TXD(line_txd), .LOOPBACK(lb), .SPEED_SEL(spd),
    .FULL_DUPLEX(fd), .AN_ENABLE(ane), .AN_RESTART(anr), .POWER_DOWN(pd),
    .ISOLATE(iso), .COLL_TEST(ct), .SOFT_RESET(srst));

  mgmt_station mgmt_station_inst (.clk(clock), .wire_lvl(mdio), .mdc(mdc),
    .drv_out(drv_out), .drv_oe(drv_oe));

  // ==========================================
  // monitors and timeout
  // pulses are counted off the launching edge, where they are settled
  always @(negedge clock) begin
    cycles++;
    n_restart += int'(anr === 1'b1);
    n_soft += int'(srst === 1'b1);
    // about forty frames of some 205 cycles each
    if (cycles == 60000) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic logic [7:0] ctl_bits(input logic [15:0] w);
    return {w[14], w[6], w[13], w[8], w[12], w[11], w[10], w[7]};
  endfunction : ctl_bits

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bits(input logic [7:0] got, input logic [7:0] exp);
    check_word({8'h00, got}, {8'h00, exp});
  endtask : check_bits

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] q;
    logic t;
    mgmt_station_inst.frame(`OP_WRITE, ME, ra, d, q, t);
  endtask : wr

  task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] q;
    logic t;
    mgmt_station_inst.frame(`OP_READ, ME, ra, 16'h0000, q, t);
    check_bits({7'h00, t}, 8'h01);
    check_word(q, exp);
  endtask : rdchk

  // random datapath traffic under control word w
  task automatic dp_check(input logic [15:0] w);
    logic ev, et;
    seed = xs(seed);
    @(negedge clock);
    tx_en = seed[0] | w[7];
    txd = seed[15:8];
    rx_valid = seed[1];
    rxd = seed[23:16];
    col = seed[2];
    repeat (2) @(negedge clock);
    ev = !w[10] && (w[14] ? tx_en : rx_valid);
    et = !(w[14] | w[11] | w[10]) && tx_en;
    check_bits({7'h00, mac_rx_valid}, {7'h00, ev});
    if (ev) check_bits(mac_rxd, w[14] ? txd : rxd);
    if (!w[14]) check_bits({7'h00, mac_col}, {7'h00, !w[10] && (w[7] ? tx_en : col)});
    check_word({line_tx_en, 7'h00, line_txd}, {et, 7'h00, et ? txd : 8'h00});
  endtask : dp_check

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // ==========================================
  // main sequence
  initial begin
    logic [15:0] w, q;
    logic t;
    {link_up, an_done, far_fault, jabber, tx_en, rx_valid, col} = 7'b1100000;
    txd = 8'h00;
    rxd = 8'h00;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    check_bits(outs, ctl_bits(16'h1040));
    mgmt_station_inst.to_main(ME);
    rdchk(`CTRL_ADDR, 16'h1040);
    rdchk(`STAT_ADDR, 16'h79e9);
    rdchk(`STAT_ADDR, 16'h79ed);
    rdchk(`ID_HI_ADDR, OHI[15:0]);
    rdchk(`ID_LO_ADDR, {OLO[5:0], MDL[5:0], RV[3:0]});
    rdchk(5'h07, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      w = seed[15:0] & 16'h7dc0;
      {w[6], w[13]} = i[1:0];
      w[14] = i[2];
      w[10] = (i == 3);
      w[7] = i[0] ^ i[1];
      wr(`CTRL_ADDR, w);
      rdchk(`CTRL_ADDR, w);
      check_bits(outs, ctl_bits(w));
      dp_check(w);
    end
    n_restart = 0;
    wr(`CTRL_ADDR, 16'h1240);
    check_word(16'(n_restart), 16'h0001);
    rdchk(`CTRL_ADDR, 16'h1040);
    wr(`CTRL_ADDR, 16'h4100);
    wr(`PAGE_ADDR, 16'h0002);
    rdchk(`CTRL_ADDR, 16'h0000);
    n_soft = 0;
    wr(`CTRL_ADDR, 16'h8000);
    wr(`PAGE_ADDR, 16'h0000);
    rdchk(`CTRL_ADDR, 16'h4100);
    wr(`CTRL_ADDR, 16'h8100);
    check_word(16'(n_soft), 16'h0001);
    rdchk(`CTRL_ADDR, 16'h1040);
    check_bits(outs, ctl_bits(16'h1040));
    @(negedge clock);
    {far_fault, jabber, link_up} = 3'b110;
    @(negedge clock);
    {far_fault, jabber, link_up} = 3'b001;
    rdchk(`STAT_ADDR, 16'h79fb);
    an_done = 1'b0;
    rdchk(`STAT_ADDR, 16'h79cd);
    mgmt_station_inst.frame(`OP_READ, ME ^ 5'h01, `CTRL_ADDR, 16'h0000, q, t);
    check_word(q, 16'hffff);
    mgmt_station_inst.force_gig(ME, 16'h0140);
    // refused writes: unknown op code, other port address
    mgmt_station_inst.frame(2'h3, ME, `CTRL_ADDR, 16'h4100, q, t);
    mgmt_station_inst.frame(`OP_WRITE, ME ^ 5'h01, `CTRL_ADDR, 16'h4100, q, t);
    rdchk(`CTRL_ADDR, 16'h0140);
    summarize();
  end
endmodule : phy_basic_control_status_regs_test
